// ### rtl/stm_pkg.sv
package stm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus shapes
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    typedef logic [ADDR_W-1:0] stm_addr_t;
    typedef logic [DATA_W-1:0] stm_data_t;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam stm_addr_t OFS_CTRL0 = 12'h000;
    localparam stm_addr_t OFS_CTRL1 = 12'h004;
    localparam stm_addr_t OFS_COUNT = 12'h008;
    localparam stm_addr_t OFS_CMPA  = 12'h00C;
    localparam stm_addr_t OFS_FLAGS = 12'h010;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned CTRL0_RUN_BIT  = 0;
    localparam int unsigned CTRL0_EXTF_BIT = 1;
    localparam int unsigned CTRL0_COMPARE_P_VALUE_LSB = 8;
    localparam int unsigned FLAG_A_BIT     = 0;
    localparam int unsigned FLAG_P_BIT     = 1;
    localparam int unsigned CTRL1_W        = 8;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam stm_data_t        DATA_ZERO  = 32'h0000_0000;
    localparam logic [CTRL1_W-1:0] CTRL1_RST = 8'h00;
    localparam logic [1:0]       FLAGS_RST  = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Modes and pin-function codes
    typedef enum logic [1:0] {
        STM_MODE_CMP = 2'b00,
        STM_MODE_CAP = 2'b01,
        STM_MODE_PWM = 2'b10,
        STM_MODE_TC  = 2'b11
    } stm_mode_e;

    localparam logic [1:0] PF_IDLE    = 2'b00;
    localparam logic [1:0] PF_CODE_A  = 2'b01;
    localparam logic [1:0] PF_CODE_B  = 2'b10;
    localparam logic [1:0] PF_SPECIAL = 2'b11;

    typedef struct packed {
        logic mode_select_hi;
        logic mode_select_lo;
        logic pin_function_hi;
        logic pin_function_lo;
        logic output_initial_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_select;
    } stm_ctrl_s;

endpackage

// ### rtl/stm_sync_edge.sv
`timescale 1ns/10ps
module stm_sync_edge (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic s1;
    logic s2;
    logic s3;

    ////////////////////////////////////////////////////////////////////////
    // Three-stage capture
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accept change once stages two and three agree
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            level <= 1'b0;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            rise <= (s2 == s3) && s3 && !level;
            fall <= (s2 == s3) && !s3 && level;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // stm_sync_edge

// ### rtl/stm_timer.sv
// What this block does
// R1 - Compare mode with clear select high: A match clears counter, no P flag.
// R2 - Compare mode: only A match and run rise change the pin, P match never.
// R3 - Compare: each run bit rising edge restores the pin to its initial level.
// R4 - Mode 11 counts like compare mode but leaves the pin undriven.
// R5 - Software sets mode 10 and pin function 10 for PWM.
// R6 - PWM: swap 0 clears on P, duty from A; swap 1 exchanges roles.
// R7 - PWM ignores clear select; clearing follows the swap bit only.
// R8 - PWM raises separate flags for A and P matches.
// R9 - PWM pin function 00/01 forces inactive/active while counting continues.
// R10 - PWM: initial-level bit picks active level, invert bit flips output.
// R11 - Narrow variant: P value k gives 128k clocks, zero gives 1024.
// R12 - Duty at or above period holds PWM output active all period.
// R13 - Wide variant swap 0: period is P times 256, zero gives 65536.
// R14 - Wide variant swap 1: A sets period, duty P times 256 or 65536.
// R15 - Single pulse: mode 10, pin function 11; run rise starts pulse.
// R16 - Single pulse: external clock pin edge sets run bit automatically.
// R17 - Single pulse: A match clears run, ends pulse, raises flag.
// R18 - Single pulse ignores P, clear select, swap; zeroed only on run rise.
// R19 - Mode 01 is capture; pin function picks edges; run rise starts.
// R20 - Capture: active edge copies counter into A and raises a flag.
// R21 - Capture: counter runs until run falls; P match wraps with flag.
// R22 - Capture: pin function 11 suppresses capture; output bits unused.
// R23 - Compare: pin function sets A match action: none, low, high, toggle.
// R24 - Wide variant compares P only against counter bits 15 to 8.
// R25 - Capture codes 00, 01, 10 select rising, falling, both edges.
`timescale 1ns/10ps
module stm_timer #(
    parameter int unsigned CNT_W = 16
) (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire stm_pkg::stm_addr_t paddr,
    input  wire stm_pkg::stm_data_t pwdata,
    output stm_pkg::stm_data_t     prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_clock_pin,
    input  wire logic              timer_pin_zero_in,
    output logic                   timer_pin_zero_out,
    output logic                   timer_pin_zero_oe,
    output logic                   match_a_flag,
    output logic                   match_p_flag
);
    import stm_pkg::*;

    localparam int unsigned P_W = (CNT_W == 10) ? 3 : 8;
    localparam int unsigned SH  = CNT_W - P_W;

    logic                 counter_run_bit;
    logic                 run_q;
    logic                 ext_fall_sel;
    logic [P_W-1:0]       compare_p_value;
    stm_ctrl_s            timer_control_one;
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     compare_a_value;
    logic                 pin_level;
    logic                 next_run;
    logic                 next_pin;
    logic                 next_oe;
    stm_mode_e            mode;
    logic [1:0]           pin_func;
    logic                 cmp_like;
    logic                 is_pwm;
    logic                 is_sp;
    logic                 is_cap;
    logic                 run_rise;
    logic                 counting;
    logic [CNT_W-1:0]     cnt_inc;
    logic [CNT_W-1:0]     p_ref;
    logic                 a_hit;
    logic                 p_hit;
    logic                 clr;
    logic                 a_set;
    logic                 p_set;
    logic                 cap_edge;
    logic [CNT_W:0]       duty;
    logic [CNT_W:0]       period;
    logic                 pwm_act;
    logic                 ext_rise;
    logic                 ext_fall;
    logic                 pin_rise;
    logic                 pin_fall;
    logic                 ext_edge;
    logic                 acc;
    logic                 wr_en;
    stm_data_t            rd_data;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic addr_mapped(input stm_addr_t a);
        return (a == OFS_CTRL0) || (a == OFS_CTRL1) || (a == OFS_COUNT) ||
               (a == OFS_CMPA) || (a == OFS_FLAGS);
    endfunction

    // Zero stands for the full count range
    function automatic logic [CNT_W:0] full_scale(input logic [CNT_W-1:0] v);
        return {v == {CNT_W{1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs
    stm_sync_edge u_ext_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (external_clock_pin),
        .level    (),
        .rise     (ext_rise),
        .fall     (ext_fall)
    );

    stm_sync_edge u_pin_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (timer_pin_zero_in),
        .level    (),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign mode     = stm_mode_e'({timer_control_one.mode_select_hi,
                                   timer_control_one.mode_select_lo});
    assign pin_func = {timer_control_one.pin_function_hi,
                       timer_control_one.pin_function_lo};
    assign cmp_like = (mode == STM_MODE_CMP) || (mode == STM_MODE_TC); // R4
    assign is_pwm   = (mode == STM_MODE_PWM) && (pin_func != PF_SPECIAL);
    assign is_sp    = (mode == STM_MODE_PWM) && (pin_func == PF_SPECIAL); // R15
    assign is_cap   = (mode == STM_MODE_CAP); // R19
    assign ext_edge = is_sp && (ext_fall_sel ? ext_fall : ext_rise); // R16

    ////////////////////////////////////////////////////////////////////////
    // Comparators
    assign run_rise = counter_run_bit && !run_q;
    assign counting = counter_run_bit && !run_q ? 1'b0 : counter_run_bit;
    assign cnt_inc  = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    assign p_ref    = {compare_p_value, {SH{1'b0}}}; // R24 R11 R13
    assign a_hit    = counting && (cnt_inc == compare_a_value);
    assign p_hit    = counting && (cnt_inc == p_ref);
    assign period   = timer_control_one.duty_period_swap ?
                      full_scale(compare_a_value) : full_scale(p_ref); // R6
    assign duty     = timer_control_one.duty_period_swap ?
                      full_scale(p_ref) : full_scale(compare_a_value); // R14
    assign pwm_act  = counter_run_bit &&
                      (run_rise || ({1'b0, cnt} < duty)); // R12

    ////////////////////////////////////////////////////////////////////////
    // Clear source and flag events per mode
    always_comb begin
        clr      = 1'b0;
        a_set    = 1'b0;
        p_set    = 1'b0;
        cap_edge = 1'b0;
        case (mode)
            STM_MODE_CMP,
            STM_MODE_TC: begin
                clr   = timer_control_one.clear_source_select ?
                        a_hit : p_hit; // R1
                a_set = a_hit;
                p_set = p_hit && !timer_control_one.clear_source_select; // R1
            end
            STM_MODE_PWM: begin
                if (is_pwm) begin
                    clr   = timer_control_one.duty_period_swap ?
                            a_hit : p_hit; // R6 R7
                    a_set = a_hit; // R8
                    p_set = p_hit; // R8
                end else begin
                    a_set = a_hit; // R17 R18
                end
            end
            STM_MODE_CAP: begin
                case (pin_func)
                    PF_IDLE:   cap_edge = pin_rise; // R25
                    PF_CODE_A: cap_edge = pin_fall; // R25
                    PF_CODE_B: cap_edge = pin_rise || pin_fall; // R25
                    default:   cap_edge = 1'b0; // R22
                endcase
                cap_edge = cap_edge && counting;
                clr      = p_hit; // R21
                a_set    = cap_edge; // R20
                p_set    = p_hit; // R21
            end
            default: begin
                clr = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    assign acc     = psel && penable;
    assign pready  = 1'b1;
    assign pslverr = acc && !addr_mapped(paddr);
    assign wr_en   = acc && pwrite && addr_mapped(paddr);

    always_comb begin
        rd_data = DATA_ZERO;
        case (paddr)
            OFS_CTRL0: begin
                rd_data[CTRL0_RUN_BIT]            = counter_run_bit;
                rd_data[CTRL0_EXTF_BIT]           = ext_fall_sel;
                rd_data[CTRL0_COMPARE_P_VALUE_LSB +: P_W]    = compare_p_value;
            end
            OFS_CTRL1: rd_data[CTRL1_W-1:0]       = timer_control_one;
            OFS_COUNT: rd_data[CNT_W-1:0]         = cnt;
            OFS_CMPA:  rd_data[CNT_W-1:0]         = compare_a_value;
            OFS_FLAGS: begin
                rd_data[FLAG_A_BIT]               = match_a_flag;
                rd_data[FLAG_P_BIT]               = match_p_flag;
            end
            default:   rd_data = DATA_ZERO;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= DATA_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_data;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_control_one <= CTRL1_RST;
            compare_p_value   <= {P_W{1'b0}};
            ext_fall_sel      <= 1'b0;
        end else if (wr_en) begin
            if (paddr == OFS_CTRL1) begin
                timer_control_one <= pwdata[CTRL1_W-1:0];
            end
            if (paddr == OFS_CTRL0) begin
                compare_p_value <= pwdata[CTRL0_COMPARE_P_VALUE_LSB +: P_W];
                ext_fall_sel    <= pwdata[CTRL0_EXTF_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run bit: hardware set wins over any clear
    always_comb begin
        next_run = counter_run_bit;
        if (wr_en && (paddr == OFS_CTRL0)) begin
            next_run = pwdata[CTRL0_RUN_BIT];
        end
        if (is_sp && a_hit) begin
            next_run = 1'b0; // R17
        end
        if (ext_edge) begin
            next_run = 1'b1; // R16
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            counter_run_bit <= 1'b0;
            run_q           <= 1'b0;
        end else begin
            counter_run_bit <= next_run;
            run_q           <= counter_run_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= {CNT_W{1'b0}};
        end else if (run_rise) begin
            cnt <= {CNT_W{1'b0}}; // R18 R19
        end else if (counting) begin
            cnt <= clr ? {CNT_W{1'b0}} : cnt_inc; // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare A register with capture priority over software
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            compare_a_value <= {CNT_W{1'b0}};
        end else if (cap_edge) begin
            compare_a_value <= cnt; // R20
        end else if (wr_en && (paddr == OFS_CMPA)) begin
            compare_a_value <= pwdata[CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags: write one to clear, new event wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {match_p_flag, match_a_flag} <= FLAGS_RST;
        end else begin
            match_a_flag <= a_set || (match_a_flag && !(wr_en &&
                            (paddr == OFS_FLAGS) && pwdata[FLAG_A_BIT]));
            match_p_flag <= p_set || (match_p_flag && !(wr_en &&
                            (paddr == OFS_FLAGS) && pwdata[FLAG_P_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare-mode pin state
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_level <= 1'b0;
        end else if (run_rise) begin
            pin_level <= timer_control_one.output_initial_level; // R3
        end else if ((mode == STM_MODE_CMP) && a_hit) begin
            case (pin_func) // R2 R23
                PF_CODE_A:  pin_level <= 1'b0;
                PF_CODE_B:  pin_level <= 1'b1;
                PF_SPECIAL: pin_level <= !pin_level;
                default:    pin_level <= pin_level;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin output select
    always_comb begin
        next_pin = 1'b0;
        next_oe  = 1'b0;
        case (mode)
            STM_MODE_CMP: begin
                next_pin = pin_level;
                next_oe  = 1'b1;
            end
            STM_MODE_PWM: begin
                next_oe = 1'b1;
                case (pin_func) // R9
                    PF_IDLE:   next_pin = 1'b0;
                    PF_CODE_A: next_pin = 1'b1;
                    PF_CODE_B: next_pin = pwm_act;
                    default:   next_pin = counter_run_bit; // R15 R17
                endcase
                next_pin = (next_pin ?
                            timer_control_one.output_initial_level :
                            !timer_control_one.output_initial_level) ^
                           timer_control_one.output_invert; // R10
            end
            default: begin
                next_pin = 1'b0; // R4 R22
                next_oe  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_pin_zero_out <= 1'b0;
            timer_pin_zero_oe  <= 1'b0;
        end else begin
            timer_pin_zero_out <= next_pin;
            timer_pin_zero_oe  <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_cclr_clear: assert property (@(posedge core_clk) // R1
        disable iff (!arst_n)
        cmp_like && timer_control_one.clear_source_select && a_hit
        |=> cnt == {CNT_W{1'b0}} && !$rose(match_p_flag))
        else $error("A match did not clear counter");

    a_pin_hold: assert property (@(posedge core_clk) // R2
        disable iff (!arst_n)
        (mode == STM_MODE_CMP) && !a_hit && !run_rise
        |=> $stable(pin_level))
        else $error("Pin moved without A match");

    a_rise_init: assert property (@(posedge core_clk) // R3
        disable iff (!arst_n)
        run_rise && (mode == STM_MODE_CMP)
        |=> pin_level == $past(timer_control_one.output_initial_level)
            ##1 timer_pin_zero_out == $past(pin_level))
        else $error("Pin not restored on run rise");

    a_tc_release: assert property (@(posedge core_clk) // R4
        disable iff (!arst_n)
        (mode == STM_MODE_TC) |=> !timer_pin_zero_oe)
        else $error("Pin driven in timer mode");

    a_pwm_period: assert property (@(posedge core_clk) // R6
        disable iff (!arst_n)
        is_pwm && p_hit && !timer_control_one.duty_period_swap
        |=> cnt == {CNT_W{1'b0}} && match_p_flag)
        else $error("P match did not end PWM period");

    a_pwm_aflag: assert property (@(posedge core_clk) // R8
        disable iff (!arst_n)
        is_pwm && a_hit |=> match_a_flag)
        else $error("A flag missing in PWM");

    a_force_act: assert property (@(posedge core_clk) // R9
        disable iff (!arst_n)
        is_pwm && (pin_func == PF_CODE_A)
        |=> timer_pin_zero_out == $past(timer_control_one.output_initial_level
            ^ timer_control_one.output_invert))
        else $error("Forced active level wrong");

    a_full_duty: assert property (@(posedge core_clk) // R12
        disable iff (!arst_n)
        is_pwm && (pin_func == PF_CODE_B) && counter_run_bit &&
        (duty >= period)
        |=> timer_pin_zero_out == $past(timer_control_one.output_initial_level
            ^ timer_control_one.output_invert))
        else $error("Full duty not held active");

    a_sp_trig: assert property (@(posedge core_clk) // R16
        disable iff (!arst_n)
        ext_edge && !counter_run_bit
        |=> counter_run_bit ##1 cnt == {CNT_W{1'b0}})
        else $error("External edge did not start pulse");

    a_sp_stop: assert property (@(posedge core_clk) // R17
        disable iff (!arst_n)
        is_sp && a_hit && !ext_edge |=> !counter_run_bit && match_a_flag)
        else $error("A match did not end pulse");

    a_cap_copy: assert property (@(posedge core_clk) // R20
        disable iff (!arst_n)
        cap_edge |=> compare_a_value == $past(cnt) && match_a_flag)
        else $error("Capture did not copy counter");

    a_cap_wrap: assert property (@(posedge core_clk) // R21
        disable iff (!arst_n)
        is_cap && p_hit |=> cnt == {CNT_W{1'b0}} && match_p_flag)
        else $error("Capture P match did not wrap");
endmodule // stm_timer

// ### tb/stm_pin_model.sv
`timescale 1ns/10ps
module stm_pin_model (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic ext_req,
    input  wire logic cap_req,
    output logic      external_clock_pin,
    output logic      timer_pin_zero_in
);
    // Source levels follow the bench request one clock later
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            external_clock_pin <= 1'b0;
            timer_pin_zero_in  <= 1'b0;
        end else begin
            external_clock_pin <= ext_req;
            timer_pin_zero_in  <= cap_req;
        end
    end
endmodule // stm_pin_model

// ### tb/standard_timer_mode_logic_bench.sv
`timescale 1ns/10ps
module standard_timer_mode_logic_bench;
    import stm_pkg::*;
    logic      core_clk = 1'b0;
    logic      arst_n   = 1'b0;
    logic      psel     = 1'b0;
    logic      penable  = 1'b0;
    logic      pwrite   = 1'b0;
    stm_addr_t paddr    = 12'h000;
    stm_data_t pwdata   = 32'h0000_0000;
    stm_data_t prdata;
    logic      pready, pslverr, ext_pin, cap_pin, pin_out, pin_oe, fa, fp;
    logic      ext_req = 1'b0;
    logic      cap_req = 1'b0;
    stm_data_t q;
    logic      slv;
    int        err_count, total_checks, hi;
    int        cfg[7]  = '{8'hA8, 8'hAC, 8'hA9, 8'hA8, 8'h88, 8'h98, 8'hAA};
    int        cmpa[7] = '{32, 32, 32, 200, 32, 32, 300};
    int        win[7]  = '{128, 128, 128, 128, 128, 128, 300};
    int        duty[7] = '{32, 96, 32, 128, 0, 128, 128};
    int        fexp[7] = '{3, 3, 3, 2, 3, 3, 3};

    always #10 core_clk = ~core_clk;

    stm_timer #(.CNT_W(10)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_pin(ext_pin),
        .timer_pin_zero_in(cap_pin), .timer_pin_zero_out(pin_out),
        .timer_pin_zero_oe(pin_oe), .match_a_flag(fa), .match_p_flag(fp)
    );

    stm_pin_model pins (
        .core_clk(core_clk), .arst_n(arst_n), .ext_req(ext_req),
        .cap_req(cap_req), .external_clock_pin(ext_pin),
        .timer_pin_zero_in(cap_pin)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict and shared tasks
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input stm_data_t got, input stm_data_t exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input stm_addr_t a,
                       input stm_data_t d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q   = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            finish_test();
        end
    endtask

    task automatic pin(input logic e_out, input logic e_oe);
        @(negedge core_clk);
        check({31'h0, pin_out}, {31'h0, e_out});
        check({31'h0, pin_oe}, {31'h0, e_oe});
    endtask

    task automatic run(input stm_data_t c1, input stm_data_t a, int w);
        apb(1'b1, OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, OFS_CTRL1, c1);
        apb(1'b1, OFS_CMPA, a);
        apb(1'b1, OFS_FLAGS, 32'h0000_0003);
        apb(1'b1, OFS_CTRL0, 32'h0000_0101);
        repeat (w) @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        apb(1'b0, OFS_CTRL1, 32'h0);
        check(q, 32'h0000_0000);
        apb(1'b0, 12'h0F0, 32'h0);
        check({31'h0, slv}, 32'h0000_0001);
        run(32'h0000_0021, 32'h0000_0003, 20);
        apb(1'b0, OFS_FLAGS, 32'h0);
        check(q, 32'h0000_0001);
        check({30'h0, fp, fa}, 32'h0000_0001);
        pin(1'b1, 1'b1);
        run(32'h0000_0001, 32'h0000_0003, 20);
        pin(1'b0, 1'b1);
        run(32'h0000_0019, 32'h0000_0003, 20);
        pin(1'b0, 1'b1);
        run(32'h0000_00C1, 32'h0000_0003, 20);
        apb(1'b0, OFS_FLAGS, 32'h0);
        check(q, 32'h0000_0001);
        pin(1'b0, 1'b0);
        for (int i = 0; i < 7; i++) begin
            run(cfg[i], cmpa[i], win[i] + 10);
            hi = 0;
            for (int k = 0; k < win[i]; k++) begin
                @(negedge core_clk);
                hi += (pin_out === 1'b1);
            end
            check(hi, duty[i]);
            apb(1'b0, OFS_FLAGS, 32'h0);
            check(q, fexp[i]);
            check({30'h0, fp, fa}, fexp[i]);
        end
        run(32'h0000_0040, 32'h0000_0000, 40);
        cap_req <= 1'b1;
        repeat (20) @(posedge core_clk);
        apb(1'b0, OFS_FLAGS, 32'h0);
        check(q, 32'h0000_0001);
        apb(1'b0, OFS_CMPA, 32'h0);
        check({31'h0, q > 40 && q < 60}, 32'h0000_0001);
        run(32'h0000_0050, 32'h0000_0000, 40);
        cap_req <= 1'b0;
        repeat (20) @(posedge core_clk);
        apb(1'b0, OFS_CMPA, 32'h0);
        check({31'h0, q > 40 && q < 60}, 32'h0000_0001);
        run(32'h0000_0070, 32'h0000_0000, 40);
        cap_req <= 1'b1;
        repeat (20) @(posedge core_clk);
        apb(1'b0, OFS_FLAGS, 32'h0);
        check(q, 32'h0000_0000);
        apb(1'b1, OFS_CTRL0, 32'h0000_0000);
        apb(1'b1, OFS_CTRL1, 32'h0000_00B8);
        apb(1'b1, OFS_CMPA, 32'h0000_0014);
        ext_req <= 1'b1;
        repeat (10) @(posedge core_clk);
        apb(1'b0, OFS_CTRL0, 32'h0);
        check(q & 32'h0000_0001, 32'h0000_0001);
        pin(1'b1, 1'b1);
        repeat (30) @(posedge core_clk);
        apb(1'b0, OFS_CTRL0, 32'h0);
        check(q & 32'h0000_0001, 32'h0000_0000);
        pin(1'b0, 1'b1);
        finish_test();
    end
endmodule // standard_timer_mode_logic_bench
